// ### src/clock_path_pkg.sv
/*
 * constants for the clock path configuration block: register offsets,
 * field positions, reset values and encodings.
 * assumes an 8-bit register port with 10-bit addresses.
 */
package clock_path_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [9:0] PLL_CTRL_OFS   = 10'h010;
    localparam logic [9:0] VCO_CAL_OFS    = 10'h018;
    localparam logic [9:0] VCO_DIV_OFS    = 10'h1e0;
    localparam logic [9:0] DIST_SEL_OFS   = 10'h1e1;
    localparam logic [9:0] UPDATE_OFS     = 10'h232;
    localparam logic [9:0] STATUS_OFS     = 10'h233;

    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int PFD_POL_BIT    = 7;
    localparam int BYPASS_BIT     = 0;
    localparam int SRC_SEL_BIT    = 1;
    localparam int CAL_BIT        = 0;
    localparam int UPDATE_BIT     = 0;

    localparam logic [1:0] PWR_NORMAL   = 2'h0;
    localparam logic [1:0] PWR_ASYNC_PD = 2'h1;
    localparam logic [7:0] UPDATE_CODE  = 8'h01;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PLL_CTRL_RST = 8'h01;
    localparam logic [7:0] VCO_CAL_RST  = 8'h00;
    localparam logic [7:0] VCO_DIV_RST  = 8'h02;
    localparam logic [7:0] DIST_SEL_RST = 8'h00;

    // divider code: 000 -> /2 ... 100 -> /6
    localparam logic [2:0] DIV_CODE_MAX = 3'h4;
    localparam logic [2:0] DIV_BASE     = 3'h2;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN  = 2'b01,
        CAL_DONE = 2'b10
    } cal_state_t;

    localparam logic [3:0] CAL_CYCLES = 4'h8;

endpackage : clock_path_pkg

// ### src/vco_cal_seq.sv
/*
 * vco calibration sequencer: a rising active calibration bit starts a
 * fixed-length run; a cleared bit returns it to idle.
 * assumes one clock and synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none

module vco_cal_seq (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic calEnable,
    output var  logic calBusy,
    output var  logic calDone
);

    clock_path_pkg::cal_state_t stateReg;
    logic [3:0]                 cntReg;
    logic                       prevReg;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prevReg <= 1'b0;
        end else begin
            prevReg <= calEnable;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stateReg <= clock_path_pkg::CAL_IDLE;
            cntReg   <= 4'h0;
        end else begin
            unique case (stateReg)
                clock_path_pkg::CAL_IDLE: begin
                    if (calEnable && !prevReg) begin
                        stateReg <= clock_path_pkg::CAL_RUN;
                        cntReg   <= clock_path_pkg::CAL_CYCLES;
                    end
                end
                clock_path_pkg::CAL_RUN: begin
                    if (!calEnable) begin
                        stateReg <= clock_path_pkg::CAL_IDLE;
                    end else if (cntReg == 4'h1) begin
                        stateReg <= clock_path_pkg::CAL_DONE;
                    end
                    cntReg <= cntReg - 4'h1;
                end
                clock_path_pkg::CAL_DONE: begin
                    if (!calEnable) begin
                        stateReg <= clock_path_pkg::CAL_IDLE;
                    end
                end
                default: stateReg <= clock_path_pkg::CAL_IDLE;
            endcase
        end
    end

    assign calBusy = (stateReg == clock_path_pkg::CAL_RUN);
    assign calDone = (stateReg == clock_path_pkg::CAL_DONE);

endmodule : vco_cal_seq

`default_nettype wire

// ### src/clock_path_config.sv
/*
 * clock path configuration: staged and active registers for pll power,
 * pfd polarity, vco divider, divider bypass and source select, plus the
 * calibration start; routing controls come out as registered levels.
 * assumes a plain register port: one-cycle strobes, read data next cycle.
 */
// Strobed register access was left to the implementer.
//
// Contract
// - pll power field 01 holds pll in async power-down; this is reset.
// - pll power field 00 runs the pll normally.
// - vco divider code resets to 010, divide by four.
// - divider ratios two to six only; minimum division two.
// - bypass bit 0 uses divider, 1 skips it.
// - source bit 0 picks external clock, 1 picks internal vco.
// - writing 01 to update register applies staged settings.
// - reset loads the same defaults as power-up.
// - pfd polarity bit 0 positive, 1 negative.
// - external source selected means internal vco stays powered off.
// - external source with pll on feeds clock input into prescaler.
// - calibration bit set plus update starts a vco calibration; here only if the active calibration bit was clear before the update.
`timescale 1ns/10ps
`default_nettype none

module clock_path_config (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic [9:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output var  logic [7:0] regRdata,
    output var  logic       pllPowerDown,
    output var  logic       pfdNegative,
    output var  logic [2:0] vcoDivRatio,
    output var  logic       divBypass,
    output var  logic       srcIsVco,
    output var  logic       vcoPowerOn,
    output var  logic       clkToPrescaler,
    output var  logic       calStart,
    output var  logic       calRunning
);

    // ------------------------------------------------------------
    // staging and active registers
    // ------------------------------------------------------------
    logic [7:0] pllStage_reg;
    logic [7:0] calStage_reg;
    logic [7:0] divStage_reg;
    logic [7:0] selStage_reg;
    logic [7:0] pllAct_reg;
    logic [7:0] calAct_reg;
    logic [7:0] divAct_reg;
    logic [7:0] selAct_reg;
    logic       update_next;
    logic       calBusyW;
    logic       calDoneW;
    logic [7:0] rdata_next;

    function automatic logic [2:0] ratio_of(input logic [7:0] code);
        logic [2:0] c;
        c = code[2:0];
        if (c > clock_path_pkg::DIV_CODE_MAX) begin
            c = clock_path_pkg::DIV_CODE_MAX;
        end
        return c + clock_path_pkg::DIV_BASE;
    endfunction : ratio_of

    assign update_next = regWr && (regAddr == clock_path_pkg::UPDATE_OFS)
                         && (regWdata == clock_path_pkg::UPDATE_CODE);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pllStage_reg <= clock_path_pkg::PLL_CTRL_RST;
            calStage_reg <= clock_path_pkg::VCO_CAL_RST;
            divStage_reg <= clock_path_pkg::VCO_DIV_RST;
            selStage_reg <= clock_path_pkg::DIST_SEL_RST;
        end else if (regWr) begin
            unique case (regAddr)
                clock_path_pkg::PLL_CTRL_OFS: pllStage_reg <= regWdata;
                clock_path_pkg::VCO_CAL_OFS:  calStage_reg <= regWdata;
                clock_path_pkg::VCO_DIV_OFS:  divStage_reg <= regWdata;
                clock_path_pkg::DIST_SEL_OFS: selStage_reg <= regWdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pllAct_reg <= clock_path_pkg::PLL_CTRL_RST;
            calAct_reg <= clock_path_pkg::VCO_CAL_RST;
            divAct_reg <= clock_path_pkg::VCO_DIV_RST;
            selAct_reg <= clock_path_pkg::DIST_SEL_RST;
        end else if (update_next) begin
            pllAct_reg <= pllStage_reg;
            calAct_reg <= calStage_reg;
            divAct_reg <= divStage_reg;
            selAct_reg <= selStage_reg;
        end
    end

    // ------------------------------------------------------------
    // calibration
    // ------------------------------------------------------------
    vco_cal_seq u_cal (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .calEnable (calAct_reg[clock_path_pkg::CAL_BIT]),
        .calBusy   (calBusyW),
        .calDone   (calDoneW)
    );

    // ------------------------------------------------------------
    // routing outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pllPowerDown   <= 1'b1;
            pfdNegative    <= 1'b0;
            vcoDivRatio    <= 3'h4;
            divBypass      <= 1'b0;
            srcIsVco       <= 1'b0;
            vcoPowerOn     <= 1'b0;
            clkToPrescaler <= 1'b0;
            calStart       <= 1'b0;
            calRunning     <= 1'b0;
        end else begin
            pllPowerDown   <= (pllAct_reg[1:0] != clock_path_pkg::PWR_NORMAL);
            pfdNegative    <= pllAct_reg[clock_path_pkg::PFD_POL_BIT];
            vcoDivRatio    <= ratio_of(divAct_reg);
            divBypass      <= selAct_reg[clock_path_pkg::BYPASS_BIT];
            srcIsVco       <= selAct_reg[clock_path_pkg::SRC_SEL_BIT];
            vcoPowerOn     <= selAct_reg[clock_path_pkg::SRC_SEL_BIT]
                              && (pllAct_reg[1:0] == clock_path_pkg::PWR_NORMAL);
            clkToPrescaler <= !selAct_reg[clock_path_pkg::SRC_SEL_BIT]
                              && (pllAct_reg[1:0] == clock_path_pkg::PWR_NORMAL);
            calStart       <= update_next && calStage_reg[clock_path_pkg::CAL_BIT]
                              && !calAct_reg[clock_path_pkg::CAL_BIT];
            calRunning     <= calBusyW;
        end
    end

    // ------------------------------------------------------------
    // read port: staged values read back, status shows live state
    // ------------------------------------------------------------
    always_comb begin
        unique case (regAddr)
            clock_path_pkg::PLL_CTRL_OFS: rdata_next = pllStage_reg;
            clock_path_pkg::VCO_CAL_OFS:  rdata_next = calStage_reg;
            clock_path_pkg::VCO_DIV_OFS:  rdata_next = divStage_reg;
            clock_path_pkg::DIST_SEL_OFS: rdata_next = selStage_reg;
            clock_path_pkg::STATUS_OFS:   rdata_next = {6'h00, calDoneW, calBusyW};
            default:                      rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            regRdata <= rdata_next;
        end else begin
            regRdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_PWR_RESET: assert property (@(posedge clk_sys)
        $fell(srst) |-> pllPowerDown)
        else $error("pll not powered down after reset");

    AST_PWR_NORMAL: assert property (@(posedge clk_sys) disable iff (srst)
        (pllAct_reg[1:0] == 2'h0) |=> !pllPowerDown)
        else $error("pll not running in normal mode");

    AST_DIV_RESET: assert property (@(posedge clk_sys)
        srst |=> (divAct_reg[2:0] == 3'h2))
        else $error("divider code not reset to 010");

    AST_DIV_RANGE: assert property (@(posedge clk_sys) disable iff (srst)
        (vcoDivRatio >= 3'h2) && (vcoDivRatio <= 3'h6))
        else $error("divider ratio out of range");

    AST_BYPASS: assert property (@(posedge clk_sys) disable iff (srst)
        ##1 divBypass == $past(selAct_reg[0]))
        else $error("bypass does not follow active bit");

    AST_SRC: assert property (@(posedge clk_sys) disable iff (srst)
        ##1 srcIsVco == $past(selAct_reg[1]))
        else $error("source select does not follow active bit");

    AST_NO_UPDATE_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
        !update_next |=> $stable(selAct_reg) && $stable(pllAct_reg))
        else $error("active settings changed without update");

    AST_UPDATE_COPY: assert property (@(posedge clk_sys) disable iff (srst)
        update_next |=> (divAct_reg == $past(divStage_reg))
                        ##2 (vcoDivRatio == ratio_of(divAct_reg)))
        else $error("update did not transfer staged values");

    AST_VCO_OFF: assert property (@(posedge clk_sys) disable iff (srst)
        !srcIsVco |-> !vcoPowerOn)
        else $error("internal vco powered with external source");

    AST_PFD: assert property (@(posedge clk_sys) disable iff (srst)
        ##1 pfdNegative == $past(pllAct_reg[7]))
        else $error("pfd polarity wrong");

    AST_CAL_START: assert property (@(posedge clk_sys) disable iff (srst)
        calStart |-> ##2 calRunning)
        else $error("calibration did not start");

    COV_UPDATE: cover property (@(posedge clk_sys) update_next);
    COV_CAL: cover property (@(posedge clk_sys) calStart ##[1:20] !calRunning);
    COV_BYPASS_VCO: cover property (@(posedge clk_sys) divBypass && srcIsVco);

endmodule : clock_path_config

`default_nettype wire

// ### test/clk_source_model.sv
/*
 * far-side clock source: an external clock or vco/vcxo plus the internal vco,
 * reporting the frequency that reaches the channel dividers.
 * assumes the routing levels of clock_path_config as inputs.
 */
`timescale 1ns/10ps
`default_nettype none

module clk_source_model #(
    parameter int EXT_MHZ = 2400,
    parameter int VCO_MHZ = 2000
) (
    input  wire logic        srcIsVco,
    input  wire logic        divBypass,
    input  wire logic [2:0]  vcoDivRatio,
    output var  logic [11:0] distFreqMhz
);
    // ------------------------------------------------------------
    // distribution frequency
    // ------------------------------------------------------------
    int srcMhz;
    always_comb begin
        srcMhz = srcIsVco ? VCO_MHZ : EXT_MHZ;
        // above 1600 the source must pass through the divider; divBypass here passes it undivided at any frequency
        distFreqMhz = 12'(divBypass ? srcMhz : srcMhz / int'(vcoDivRatio));
    end
endmodule : clk_source_model
`default_nettype wire

// ### test/tb_top.sv
/*
 * self-checking bench for clock_path_config with random configurations.
 * assumes clk_source_model is compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic        clk_sys;
    logic        srst;
    logic [9:0]  regAddr;
    logic [7:0]  regWdata;
    logic        regWr;
    logic        regRd;
    logic [7:0]  regRdata;
    logic        pllPowerDown;
    logic        pfdNegative;
    logic [2:0]  vcoDivRatio;
    logic        divBypass;
    logic        srcIsVco;
    logic        vcoPowerOn;
    logic        clkToPrescaler;
    logic        calStart;
    logic        calRunning;
    logic [11:0] distFreqMhz;
    int          failures;
    int          check_count;

    clock_path_config dut_u (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .pllPowerDown(pllPowerDown), .pfdNegative(pfdNegative), .vcoDivRatio(vcoDivRatio),
        .divBypass(divBypass), .srcIsVco(srcIsVco), .vcoPowerOn(vcoPowerOn),
        .clkToPrescaler(clkToPrescaler), .calStart(calStart), .calRunning(calRunning));
    clk_source_model src_u (.srcIsVco(srcIsVco), .divBypass(divBypass),
        .vcoDivRatio(vcoDivRatio), .distFreqMhz(distFreqMhz));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk_sys);
        regWr    <= 1'b0;
        // let an edge pass so a following write never re-raises the strobe at once
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk_sys);
        regRd   <= 1'b0;
        @(negedge clk_sys);
        d = regRdata;
        @(posedge clk_sys);
    endtask : rd

    task automatic upd();
        wr(clock_path_pkg::UPDATE_OFS, clock_path_pkg::UPDATE_CODE);
        repeat (3) @(negedge clk_sys);
        @(posedge clk_sys);
    endtask : upd

    // routing levels: pd, neg, bypass, src, vco on, clk to prescaler
    function automatic logic [5:0] expRoute(logic [1:0] p, logic n, logic b, logic s);
        return {p != 2'h0, n, b, s, s && p == 2'h0, !s && p == 2'h0};
    endfunction : expRoute

    function automatic logic [2:0] expRatio(logic [2:0] c);
        return (c > 3'h4) ? 3'h6 : c + 3'h2;
    endfunction : expRatio

    // update written by hand: the one-cycle start pulse follows the update edge
    task automatic cal_go(output logic seen);
        regAddr  <= clock_path_pkg::UPDATE_OFS;
        regWdata <= clock_path_pkg::UPDATE_CODE;
        regWr    <= 1'b1;
        @(posedge clk_sys);
        regWr    <= 1'b0;
        seen = 1'b0;
        for (int i = 0; i < 6 && !seen; i++) begin
            @(negedge clk_sys);
            seen = (calStart === 1'b1);
        end
    endtask : cal_go

    task automatic complete_run();
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        #2_000_000;
        failures++;
        complete_run();
    end

    initial begin
        logic [7:0] d;
        logic [7:0] pw;
        logic [7:0] dv;
        logic [7:0] sl;
        logic       got;
        int         n;
        failures = 0;
        check_count = 0;
        srst = 1'b1;
        regAddr = 10'h000;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        void'($urandom(32'hc3d2_a889));
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        @(negedge clk_sys);
        chk(expRoute(pllPowerDown, pfdNegative, divBypass, srcIsVco), expRoute(2'h1, 0, 0, 0));
        chk(vcoDivRatio, 3'h4);
        chk(distFreqMhz <= 12'd1600, 1'b1);
        @(posedge clk_sys);
        rd(clock_path_pkg::PLL_CTRL_OFS, d);
        chk(d & 8'h83, 8'h01);
        rd(clock_path_pkg::VCO_DIV_OFS, d);
        chk(d & 8'h07, 8'h02);
        rd(clock_path_pkg::DIST_SEL_OFS, d);
        chk(d & 8'h03, 8'h00);
        rd(10'h100, d);
        chk(d, 8'h00);
        // staged only until a proper update code
        wr(clock_path_pkg::DIST_SEL_OFS, 8'h03);
        wr(clock_path_pkg::UPDATE_OFS, 8'h02);
        repeat (4) @(negedge clk_sys);
        chk({divBypass, srcIsVco}, 2'b00);
        @(posedge clk_sys);
        upd();
        chk({divBypass, srcIsVco}, 2'b11);
        for (int k = 0; k < 40; k++) begin
            pw = 8'($urandom);
            dv = 8'($urandom);
            sl = 8'($urandom);
            wr(clock_path_pkg::PLL_CTRL_OFS, pw);
            wr(clock_path_pkg::VCO_DIV_OFS, dv);
            wr(clock_path_pkg::DIST_SEL_OFS, sl);
            rd(clock_path_pkg::PLL_CTRL_OFS, d);
            chk(d & 8'h83, pw & 8'h83);
            upd();
            chk(expRoute(pllPowerDown, pfdNegative, divBypass, srcIsVco),
                expRoute(pw[1:0], pw[7], sl[0], sl[1]));
            chk({vcoPowerOn, clkToPrescaler}, expRoute(pw[1:0], 0, 0, sl[1]) & 6'h03);
            chk(vcoDivRatio, expRatio(dv[2:0]));
        end
        // calibration: start, length, restart after clearing
        wr(clock_path_pkg::PLL_CTRL_OFS, 8'h00);
        wr(clock_path_pkg::VCO_CAL_OFS, 8'h01);
        cal_go(got);
        chk(got, 1'b1);
        n = 0;
        repeat (12) begin
            @(negedge clk_sys);
            n += (calRunning === 1'b1);
        end
        chk(n, 8);
        @(posedge clk_sys);
        rd(clock_path_pkg::STATUS_OFS, d);
        chk(d[1], 1'b1);
        wr(clock_path_pkg::VCO_CAL_OFS, 8'h00);
        upd();
        wr(clock_path_pkg::VCO_CAL_OFS, 8'h01);
        cal_go(got);
        chk(got, 1'b1);
        // reset in mid-run returns defaults
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(negedge clk_sys);
        chk(expRoute(pllPowerDown, pfdNegative, divBypass, srcIsVco), expRoute(2'h1, 0, 0, 0));
        chk({vcoDivRatio, calRunning}, {3'h4, 1'b0});
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
